// [bsa_pkg.sv]
package bsa_pkg;
  // Register byte offsets on the AXI4-Lite slave.
  localparam logic [7:0] OFS_MICRO = 8'h00;
  localparam logic [7:0] OFS_EXEC = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_AC = 8'h0C;
  localparam logic [7:0] OFS_T = 8'h10;
  // Microinstruction field positions, bit n of the word is microinstruction bit n.
  localparam int POS_INHIBIT = 0;
  localparam int POS_FG = 1;
  localparam int POS_RG = 4;
  localparam int POS_WS = 8;
  localparam int POS_KS = 10;
  localparam int POS_IMM = 24;
  // Bit positions in the execute register.
  localparam int POS_STEP = 0;
  localparam int POS_CIN = 1;
  // Width select codes.
  localparam logic [1:0] WS_LOWER = 2'h3;
  localparam logic [1:0] WS_UPPER = 2'h2;
  // Mask source codes; the remaining codes take the immediate field.
  localparam logic [1:0] KS_ONES = 2'h0;
  localparam logic [1:0] KS_ZEROS = 2'h1;
  // Function groups handled here.
  localparam logic [2:0] FG_4 = 3'h4;
  localparam logic [2:0] FG_5 = 3'h5;
  localparam logic [2:0] FG_6 = 3'h6;
  localparam logic [2:0] FG_7 = 3'h7;
  // Register codes outside the scratch range.
  localparam logic [3:0] R_T_II = 4'hA;
  localparam logic [3:0] R_AC_II = 4'hB;
  localparam logic [3:0] R_T_I = 4'hC;
  localparam logic [3:0] R_AC_I = 4'hD;
  localparam logic [3:0] R_T_III = 4'hE;
  localparam logic [3:0] R_AC_III = 4'hF;
  localparam int N_SCRATCH = 10;
  localparam int N_SLICES = 8;
  // Values after reset; the micro word starts with the clock inhibited.
  localparam logic [31:0] RST_MICRO = 32'h0000_0001;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  typedef enum logic [2:0] {
    GRP_I = 3'b001,
    GRP_II = 3'b010,
    GRP_III = 3'b100
  } bsa_grp_t;
endpackage

// [bsa_array.sv]
// The AXI4-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
// What this block does
// - F4 group II: M AND AC AND K.
// - F4 group III: register AND I AND K.
// - F5 group I: scratch becomes K AND scratch.
// - F5 group II: K AND M into AC/T.
// - F5 group III: K AND register, nonzero test.
// - F6 group I: scratch OR (AC AND K).
// - F6 group II: M OR (AC AND K).
// - F6 group III: register OR (I AND K).
// - F7 group I: scratch XNOR (K AND AC).
// - F7 group II: M XNOR (K AND AC).
// - F7 group III: register XNOR (K AND I).
// - F4 group I: scratch AND AC AND K.
// - Eight 2-bit slices, two bytes of four.
// - Width code gates each byte clock.
// - Inhibit bit stops both byte clocks.
// - Shared function code, write on micro clock.
// - Data outputs drive all 16 AC bits.
// - Address outputs enabled by access grant.
// - M-bus taken straight from processor bus.
// - Mask is ones, zeros or immediate, active low.
// - Carries and shift output steered by mode.
// - Top active carry latched into branch flag.
// - Carry and flag work with clock suppressed.
module bsa_array (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [15:0] mbus_i,
  input wire logic [15:0] ibus_i,
  input wire logic slice_bus_drive_enable_n_i,
  input wire logic access_granted_i,
  output logic [15:0] data_o,
  output logic data_oe_o,
  output logic [15:0] addr_o,
  output logic addr_oe_o,
  output logic branch_test_flag_o,
  output logic carry_out_o,
  output logic shift_out_o
);

  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] micro;
    logic [15:0] ac;
    logic [15:0] t;
    logic [bsa_pkg::N_SCRATCH-1:0][15:0] scr;
    logic test_flag;
    logic carry_out;
    logic shift_out;
    logic [15:0] data;
    logic data_oe;
    logic [15:0] addr;
    logic addr_oe;
  } bsa_state_t;

  bsa_state_t q_r;
  bsa_state_t q_nxt;

  function automatic bsa_pkg::bsa_grp_t grp_of(input logic [3:0] code);
    if (code == bsa_pkg::R_T_II || code == bsa_pkg::R_AC_II) begin
      grp_of = bsa_pkg::GRP_II;
    end else if (code == bsa_pkg::R_T_III || code == bsa_pkg::R_AC_III) begin
      grp_of = bsa_pkg::GRP_III;
    end else begin
      grp_of = bsa_pkg::GRP_I;
    end
  endfunction

  function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] strb);
    merge_strb = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        merge_strb[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
  endfunction

  logic step;
  logic cin;
  logic inhibit;
  logic [2:0] fg;
  logic [3:0] rg;
  logic [1:0] ws;
  logic [1:0] ks;
  bsa_pkg::bsa_grp_t grp;
  logic up_en;
  logic lo_en;
  logic [15:0] mask_n;
  logic [15:0] kword;
  logic [15:0] rn;
  logic [15:0] at;
  logic [15:0] res;
  logic [15:0] term;
  logic wr_en;
  logic [bsa_pkg::N_SLICES:0] chain;
  logic co_top;
  logic [15:0] wmask;
  logic [15:0] newval;
  logic [15:0] dest;
  logic wr_commit;

  always_comb begin
    inhibit = q_r.micro[bsa_pkg::POS_INHIBIT];
    // The lowest micro word bit of each code field is that field's most significant bit.
    fg = {q_r.micro[bsa_pkg::POS_FG], q_r.micro[bsa_pkg::POS_FG+1], q_r.micro[bsa_pkg::POS_FG+2]};
    rg = {q_r.micro[bsa_pkg::POS_RG], q_r.micro[bsa_pkg::POS_RG+1],
          q_r.micro[bsa_pkg::POS_RG+2], q_r.micro[bsa_pkg::POS_RG+3]};
    ws = {q_r.micro[bsa_pkg::POS_WS], q_r.micro[bsa_pkg::POS_WS+1]};
    ks = {q_r.micro[bsa_pkg::POS_KS], q_r.micro[bsa_pkg::POS_KS+1]};
    grp = grp_of(rg);
    wr_commit = q_r.aw_got && q_r.w_got && !q_r.bvalid;
    step = wr_commit && q_r.awaddr == bsa_pkg::OFS_EXEC && q_r.wstrb[0] && q_r.wdata[bsa_pkg::POS_STEP];
    cin = q_r.wdata[bsa_pkg::POS_CIN];
    // Mask pins are active low; the slices see the inverted pin levels.
    case (ks)
      bsa_pkg::KS_ONES: mask_n = 16'h0000;
      bsa_pkg::KS_ZEROS: mask_n = 16'hFFFF;
      default: mask_n = ~{2{q_r.micro[bsa_pkg::POS_IMM +: 8]}};
    endcase
    kword = ~mask_n;
    // Byte clock gating; the upper byte is bits 15:8, the lower byte 7:0.
    up_en = !inhibit && ws != bsa_pkg::WS_LOWER;
    lo_en = !inhibit && ws != bsa_pkg::WS_UPPER;
    wmask = {{8{up_en}}, {8{lo_en}}};
    if (rg == bsa_pkg::R_T_I) begin
      rn = q_r.t;
    end else if (rg == bsa_pkg::R_AC_I) begin
      rn = q_r.ac;
    end else if (rg < 4'(bsa_pkg::N_SCRATCH)) begin
      rn = q_r.scr[rg];
    end else begin
      rn = bsa_pkg::RST_WORD;
    end
    at = (rg == bsa_pkg::R_T_II || rg == bsa_pkg::R_T_III) ? q_r.t : q_r.ac;
    // Every slice decodes the same function code.
    wr_en = 1'b1;
    res = rn;
    term = 16'h0000;
    case (fg)
      bsa_pkg::FG_4: begin
        case (grp)
          bsa_pkg::GRP_I: res = rn & q_r.ac & kword;
          bsa_pkg::GRP_II: res = mbus_i & q_r.ac & kword;
          bsa_pkg::GRP_III: res = at & ibus_i & kword;
          default: res = rn;
        endcase
        term = res;
      end
      bsa_pkg::FG_5: begin
        case (grp)
          bsa_pkg::GRP_I: res = kword & rn;
          bsa_pkg::GRP_II: res = kword & mbus_i;
          bsa_pkg::GRP_III: res = kword & at;
          default: res = rn;
        endcase
        term = res;
      end
      bsa_pkg::FG_6: begin
        case (grp)
          bsa_pkg::GRP_I: begin
            res = rn | (q_r.ac & kword);
            term = q_r.ac & kword;
          end
          bsa_pkg::GRP_II: begin
            res = mbus_i | (q_r.ac & kword);
            term = q_r.ac & kword;
          end
          bsa_pkg::GRP_III: begin
            res = at | (ibus_i & kword);
            term = ibus_i & kword;
          end
          default: res = rn;
        endcase
      end
      bsa_pkg::FG_7: begin
        case (grp)
          bsa_pkg::GRP_I: begin
            res = ~(rn ^ (kword & q_r.ac));
            term = rn & q_r.ac & kword;
          end
          bsa_pkg::GRP_II: begin
            res = ~(mbus_i ^ (kword & q_r.ac));
            term = q_r.ac & kword & mbus_i;
          end
          bsa_pkg::GRP_III: begin
            res = ~(at ^ (kword & ibus_i));
            term = at & ibus_i & kword;
          end
          default: res = rn;
        endcase
      end
      default: wr_en = 1'b0;
    endcase
    // Slice carry chain; the upper byte is fed by the lower byte only in full-word mode.
    chain[0] = cin;
    for (int s = 0; s < bsa_pkg::N_SLICES; s++) begin
      if (s == bsa_pkg::N_SLICES / 2 && (ws == bsa_pkg::WS_LOWER || ws == bsa_pkg::WS_UPPER)) begin
        chain[s+1] = cin | (|term[2*s +: 2]);
      end else begin
        chain[s+1] = chain[s] | (|term[2*s +: 2]);
      end
    end
    co_top = (ws == bsa_pkg::WS_LOWER) ? chain[bsa_pkg::N_SLICES/2] : chain[bsa_pkg::N_SLICES];
    // Inhibited or idle steps shift out the destination's unchanged bit.
    dest = (grp == bsa_pkg::GRP_I) ? rn : at;
    newval = wr_en ? ((dest & ~wmask) | (res & wmask)) : dest;
  end

  always_comb begin
    q_nxt = q_r;
    if (s_axi_awvalid_i && q_r.awready) begin
      q_nxt.aw_got = 1'b1;
      q_nxt.awaddr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && q_r.wready) begin
      q_nxt.w_got = 1'b1;
      q_nxt.wdata = s_axi_wdata_i;
      q_nxt.wstrb = s_axi_wstrb_i;
    end
    if (q_r.bvalid && s_axi_bready_i) begin
      q_nxt.bvalid = 1'b0;
    end
    if (wr_commit) begin
      q_nxt.aw_got = 1'b0;
      q_nxt.w_got = 1'b0;
      q_nxt.bvalid = 1'b1;
      q_nxt.bresp = bsa_pkg::RESP_OKAY;
      case (q_r.awaddr)
        bsa_pkg::OFS_MICRO: q_nxt.micro = merge_strb(q_r.micro, q_r.wdata, q_r.wstrb);
        bsa_pkg::OFS_EXEC: q_nxt.micro = q_r.micro;
        default: q_nxt.bresp = bsa_pkg::RESP_DECERR;
      endcase
    end
    if (step) begin
      // Carry and flag are captured even when both byte clocks are inhibited.
      q_nxt.test_flag = co_top;
      q_nxt.carry_out = co_top;
      q_nxt.shift_out = (ws == bsa_pkg::WS_UPPER) ? newval[8] : newval[0];
      if (wr_en) begin
        if (grp != bsa_pkg::GRP_I || rg == bsa_pkg::R_T_I || rg == bsa_pkg::R_AC_I) begin
          if (rg == bsa_pkg::R_T_I || rg == bsa_pkg::R_T_II || rg == bsa_pkg::R_T_III) begin
            q_nxt.t = (q_r.t & ~wmask) | (res & wmask);
          end else begin
            q_nxt.ac = (q_r.ac & ~wmask) | (res & wmask);
          end
        end else if (rg < 4'(bsa_pkg::N_SCRATCH)) begin
          q_nxt.scr[rg] = (q_r.scr[rg] & ~wmask) | (res & wmask);
        end
      end
    end
    if (s_axi_rvalid_o && s_axi_rready_i) begin
      q_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid_i && q_r.arready) begin
      q_nxt.rvalid = 1'b1;
      q_nxt.rresp = bsa_pkg::RESP_OKAY;
      case (s_axi_araddr_i)
        bsa_pkg::OFS_MICRO: q_nxt.rdata = q_r.micro;
        bsa_pkg::OFS_EXEC: q_nxt.rdata = 32'h0000_0000;
        bsa_pkg::OFS_STATUS: q_nxt.rdata = {29'h0, q_r.shift_out, q_r.carry_out, q_r.test_flag};
        bsa_pkg::OFS_AC: q_nxt.rdata = {16'h0000, q_r.ac};
        bsa_pkg::OFS_T: q_nxt.rdata = {16'h0000, q_r.t};
        default: begin
          q_nxt.rdata = 32'h0000_0000;
          q_nxt.rresp = bsa_pkg::RESP_DECERR;
        end
      endcase
    end
    // All sixteen AC bits go out whatever the width mode.
    q_nxt.data = q_nxt.ac;
    q_nxt.data_oe = !slice_bus_drive_enable_n_i;
    q_nxt.addr = q_nxt.ac;
    q_nxt.addr_oe = access_granted_i;
    q_nxt.awready = !q_nxt.aw_got && !q_nxt.bvalid;
    q_nxt.wready = !q_nxt.w_got && !q_nxt.bvalid;
    q_nxt.arready = !q_nxt.rvalid;
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      q_r <= '0;
      q_r.micro <= bsa_pkg::RST_MICRO;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign s_axi_awready_o = q_r.awready;
  assign s_axi_wready_o = q_r.wready;
  assign s_axi_bvalid_o = q_r.bvalid;
  assign s_axi_bresp_o = q_r.bresp;
  assign s_axi_arready_o = q_r.arready;
  assign s_axi_rvalid_o = q_r.rvalid;
  assign s_axi_rdata_o = q_r.rdata;
  assign s_axi_rresp_o = q_r.rresp;
  assign data_o = q_r.data;
  assign data_oe_o = q_r.data_oe;
  assign addr_o = q_r.addr;
  assign addr_oe_o = q_r.addr_oe;
  assign branch_test_flag_o = q_r.test_flag;
  assign carry_out_o = q_r.carry_out;
  assign shift_out_o = q_r.shift_out;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  logic full_mode;
  assign full_mode = ws != bsa_pkg::WS_LOWER && ws != bsa_pkg::WS_UPPER;

  inhibit_hold_a: assert property (step && inhibit |=> $stable(q_r.ac) && $stable(q_r.t) && $stable(q_r.scr))
    else $error("Register changed with clock inhibited.");
  upper_gate_a: assert property (step && ws == bsa_pkg::WS_LOWER |=> q_r.ac[15:8] == $past(q_r.ac[15:8]))
    else $error("Upper byte written in lower-byte mode.");
  lower_gate_a: assert property (step && ws == bsa_pkg::WS_UPPER |=> q_r.t[7:0] == $past(q_r.t[7:0]))
    else $error("Lower byte written in upper-byte mode.");
  test_nondestr_a: assert property (step && inhibit && full_mode && fg == bsa_pkg::FG_5 && rg == bsa_pkg::R_AC_III
    |=> branch_test_flag_o == ($past(cin) | (|($past(q_r.ac) & $past(kword)))))
    else $error("Test flag wrong during inhibited test.");
  f5_and_m_a: assert property (step && !inhibit && full_mode && fg == bsa_pkg::FG_5 && rg == bsa_pkg::R_AC_II
    |=> q_r.ac == ($past(kword) & $past(mbus_i)))
    else $error("AND of mask and M-bus not stored.");
  f4_scratch_a: assert property (step && !inhibit && full_mode && fg == bsa_pkg::FG_4 && rg == 4'h0
    |=> q_r.scr[0] == ($past(q_r.scr[0]) & $past(q_r.ac) & $past(kword)))
    else $error("Scratch AND result wrong.");
  f6_or_m_a: assert property (step && !inhibit && full_mode && fg == bsa_pkg::FG_6 && rg == bsa_pkg::R_T_II
    |=> q_r.t == ($past(mbus_i) | ($past(q_r.ac) & $past(kword))))
    else $error("OR into T wrong.");
  f7_xnor_a: assert property (step && !inhibit && full_mode && fg == bsa_pkg::FG_7 && rg == bsa_pkg::R_AC_III
    |=> q_r.ac == ~($past(q_r.ac) ^ ($past(kword) & $past(ibus_i))))
    else $error("XNOR into AC wrong.");
  lower_flag_a: assert property (step && ws == bsa_pkg::WS_LOWER && fg == bsa_pkg::FG_5 && rg == bsa_pkg::R_AC_III
    |=> branch_test_flag_o == ($past(cin) | (|($past(q_r.ac[7:0]) & $past(kword[7:0])))))
    else $error("Lower-byte flag not from lower top stage.");
  mask_zero_a: assert property (ks == bsa_pkg::KS_ZEROS |-> kword == 16'h0000)
    else $error("Zero mask not selected.");
  drive_en_a: assert property (!slice_bus_drive_enable_n_i ##1 1'b1 |-> data_oe_o && data_o == q_r.ac)
    else $error("Data outputs not driven.");
  addr_en_a: assert property (access_granted_i |=> addr_oe_o && addr_o == q_r.ac)
    else $error("Address outputs not enabled.");

  step_inhib_c: cover property (step && inhibit);
  step_full_c: cover property (step && !inhibit && full_mode && wr_en);
  step_lower_c: cover property (step && !inhibit && ws == bsa_pkg::WS_LOWER && wr_en);

endmodule

// [bsa_pbus_model.sv]
`timescale 1ns/1ps
// Processor bus sources that feed the M-bus, picked by the bus source field.
module bsa_pbus_model (
  input wire logic clk_i,
  input wire logic [2:0] src_i,
  input wire logic [15:0] ext_i,
  input wire logic [15:0] data_i,
  input wire logic data_oe_i,
  output logic [15:0] mbus_o
);
  logic [15:0] flt_r;
  initial flt_r = 16'h5A5A;
  // A floating bus must never look like the last word driven, so it toggles each cycle.
  always @(posedge clk_i) begin
    flt_r <= ~flt_r;
  end
  always_comb begin
    case (src_i)
      3'h0: mbus_o = 16'h0000;
      3'h1: mbus_o = data_oe_i ? data_i : flt_r;
      3'h3: mbus_o = ext_i;
      default: mbus_o = flt_r;
    endcase
  end
endmodule

// [bitslice_alu_array_bench.sv]
`timescale 1ns/1ps
module bitslice_alu_array_bench;
  typedef struct packed {logic [31:0] d; logic [31:0] m; logic [1:0] r;} bsa_rd_t;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hF;
  logic [15:0] ibus = 16'h0000, ext = 16'h0000;
  logic sbde_n = 1'b1, grant = 1'b0;
  logic [2:0] src = 3'h0;
  logic awready, wready, bvalid, arready, rvalid, data_oe, addr_oe, flag_o, co_o, so_o;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] data_o, addr_o, mbus;
  int err_total = 0, cmp_count = 0, cyc = 0, seed = 96573;
  bsa_rd_t rq[$];
  logic [1:0] bq[$];
  logic [15:0] sc [0:9] = '{default: 16'h0000};
  logic [15:0] m_t = 16'h0000, m_ac = 16'h0000;
  logic m_flag = 1'b0;
  logic [3:0] rcs [0:6] = '{4'h0, 4'hC, 4'hD, 4'hA, 4'hB, 4'hE, 4'hF};

  always #2 clk_i = ~clk_i;

  bsa_array u_bsa_array (.clk_i(clk_i), .reset_n_i(reset_n_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .mbus_i(mbus), .ibus_i(ibus), .slice_bus_drive_enable_n_i(sbde_n), .access_granted_i(grant),
    .data_o(data_o), .data_oe_o(data_oe), .addr_o(addr_o), .addr_oe_o(addr_oe),
    .branch_test_flag_o(flag_o), .carry_out_o(co_o), .shift_out_o(so_o));

  bsa_pbus_model u_bsa_pbus_model (.clk_i(clk_i), .src_i(src), .ext_i(ext), .data_i(data_o),
    .data_oe_i(data_oe), .mbus_o(mbus));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cmp_rd(input bsa_rd_t e, input logic [31:0] d, input logic [1:0] r);
    chk(d & e.m, e.d & e.m);
    chk({30'h0, r}, {30'h0, e.r});
  endtask
  task automatic cmp_resp(input logic [1:0] e, input logic [1:0] r);
    chk({30'h0, r}, {30'h0, e});
  endtask
  task automatic cmp_pin(input logic [15:0] g, input logic [15:0] e);
    chk({16'h0, g}, {16'h0, e});
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Results are judged where the answer appears, oldest expectation first.
  always @(posedge clk_i) begin
    if (reset_n_i && rvalid && rready && rq.size() > 0) cmp_rd(rq.pop_front(), rdata, rresp);
    if (reset_n_i && bvalid && bready && bq.size() > 0) cmp_resp(bq.pop_front(), bresp);
  end

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      $display("unexpected at %0t: run too long", $time);
      complete_run();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    logic av, wv;
    bq.push_back(er);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    av = 1'b1;
    wv = 1'b1;
    while (av || wv) begin
      @(posedge clk_i);
      if (av && awready) begin
        av = 1'b0;
        awvalid <= 1'b0;
      end
      if (wv && wready) begin
        wv = 1'b0;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge clk_i);
    bready <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] er);
    rq.push_back('{e, m, er});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk_i); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk_i); while (rvalid !== 1'b1);
    rready <= 1'b0;
    @(posedge clk_i);
  endtask

  // One microinstruction: load it, fire one step, then check registers, flag and pins.
  task automatic step(input logic [2:0] fg, input logic [3:0] rc, input logic [1:0] ws, input logic [1:0] ks,
                      input logic inh, input logic cin);
    logic [31:0] w, r;
    logic [15:0] k, wm, a, b, ct, res, m, tv, iv, ev, nv;
    logic sh;
    r = $random(seed);
    iv = $random(seed);
    ev = $random(seed);
    // A palindromic immediate reads the same whichever end of the field is taken as its top.
    w = {r[0], r[1], r[2], r[3], r[3:0], 24'h000000};
    w[0] = inh;
    for (int i = 0; i < 3; i++) w[1 + i] = fg[2 - i];
    for (int i = 0; i < 4; i++) w[4 + i] = rc[3 - i];
    w[9:8] = {ws[0], ws[1]};
    w[11:10] = {ks[0], ks[1]};
    src <= (r[5:4] == 2'h0) ? 3'h0 : (r[5:4] == 2'h1) ? 3'h1 : 3'h3;
    w[15:13] = (r[5:4] == 2'h0) ? 3'h0 : (r[5:4] == 2'h1) ? 3'h4 : 3'h6;
    sbde_n <= r[6] & (r[5:4] != 2'h1);
    grant <= r[7];
    ibus <= iv;
    ext <= ev;
    m = (r[5:4] == 2'h0) ? 16'h0000 : (r[5:4] == 2'h1) ? m_ac : ev;
    k = (ks == 2'h0) ? 16'hFFFF : (ks == 2'h1) ? 16'h0000 : {w[31:24], w[31:24]};
    wr(8'h00, w, 4'hF, 2'h0);
    wr(8'h04, {30'h0, cin, 1'b1}, 4'h1, 2'h0);
    tv = (rc < 4'hA) ? sc[rc] : (rc[0] ? m_ac : m_t);
    a = (rc == 4'hA || rc == 4'hB) ? m : tv;
    b = (rc >= 4'hE) ? iv : m_ac;
    case (fg)
      3'h4: res = a & b & k;
      3'h5: res = a & k;
      3'h6: res = a | (b & k);
      3'h7: res = ~(a ^ (b & k));
      default: res = tv;
    endcase
    case (fg)
      3'h4, 3'h5: ct = res;
      3'h6: ct = b & k;
      3'h7: ct = a & b & k;
      default: ct = 16'h0000;
    endcase
    wm = (ws == 2'h3) ? 16'h00FF : (ws == 2'h2) ? 16'hFF00 : 16'hFFFF;
    m_flag = cin | (|(ct & wm));
    nv = tv;
    if (!inh && fg[2]) begin
      res = (tv & ~wm) | (res & wm);
      nv = res;
      if (rc < 4'hA) sc[rc] = res;
      else if (rc[0]) m_ac = res;
      else m_t = res;
    end
    // The right-shift output is the low bit of the lowest active byte after the step, bit 8 in upper-byte mode.
    sh = (ws == 2'h2) ? nv[8] : nv[0];
    rd(8'h08, {29'h0, sh, m_flag, m_flag}, 32'h0000_0007, 2'h0);
    rd(8'h0C, {16'h0, m_ac}, 32'hFFFF_FFFF, 2'h0);
    rd(8'h10, {16'h0, m_t}, 32'hFFFF_FFFF, 2'h0);
    cmp_pin({15'h0, flag_o}, {15'h0, m_flag});
    cmp_pin({15'h0, co_o}, {15'h0, m_flag});
    cmp_pin({15'h0, so_o}, {15'h0, sh});
    cmp_pin({15'h0, data_oe}, {15'h0, ~sbde_n});
    cmp_pin({15'h0, addr_oe}, {15'h0, grant});
    if (!sbde_n) cmp_pin(data_o, m_ac);
    if (grant) cmp_pin(addr_o, m_ac);
  endtask

  initial begin
    repeat (8) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rd(8'h00, 32'h0000_0001, 32'hFFFF_FFFF, 2'h0);
    rd(8'h08, 32'h0, 32'h0000_0007, 2'h0);
    rd(8'h0C, 32'h0, 32'hFFFF_FFFF, 2'h0);
    rd(8'h04, 32'h0, 32'hFFFF_FFFF, 2'h0);
    rd(8'h14, 32'h0, 32'h0, 2'h3);
    wr(8'h18, 32'hFFFF_FFFF, 4'hF, 2'h3);
    step(3'h5, 4'hB, 2'h0, 2'h0, 1'b0, 1'b0);
    step(3'h5, 4'hA, 2'h0, 2'h0, 1'b0, 1'b0);
    for (int i = 0; i < 10; i++) step(3'h6, 4'(i), 2'h0, 2'h0, 1'b0, 1'b0);
    // Every group, register kind and width code, with random masks, inhibit and carry.
    for (int i = 0; i < 112; i++) begin
      rcs[0] = 4'({$random(seed)} % 10);
      step(3'(4 + i % 4), rcs[(i / 4) % 7], 2'((i / 28) % 4), 2'($random(seed)),
           1'({$random(seed)} % 4 == 0), 1'($random(seed)));
    end
    for (int i = 0; i < 8; i++) step(3'(i % 4), 4'hD, 2'(i / 4), 2'h0, 1'b0, 1'(i));
    complete_run();
  end
endmodule
